// ==== core/phy_mgmt_pkg.sv ====
// Constants for the per-port page select, event counters and coding-sublayer config
//
// Behaviour
// - Page selector picks set at 14h-1Fh
// - Reserved selector and counter bits read zero
// - False carrier tally counts each event
// - False carrier tally sticks at FFh
// - Receive error counts invalid symbol during carrier
// - At most one count per carrier
// - No count when carrier saw collision
// - Receive error tally sticks at maximum
// - Free-clock bit selects free receive clock
// - Quiet-transmit bit selects true quiet mode
// - Signal-detect force forces signal detection
// - Option one: lock loss keeps link
// - Option zero: lock loss drops link
// - Descrambler timeout 722us or 2ms
// - Fiber bit loaded from strap, writable
// - Forced-good-link bit reports good link
package phy_mgmt_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0] ADDR_PAGE_SEL = 5'h13;
  localparam logic [4:0] ADDR_FALSE_CARRIER = 5'h14;
  localparam logic [4:0] ADDR_RX_ERROR = 5'h15;
  localparam logic [4:0] ADDR_CODING_CFG = 5'h16;
  localparam logic [4:0] ADDR_PAGED_LO = 5'h14;
  localparam logic [4:0] ADDR_PAGED_HI = 5'h1F;
  localparam logic [1:0] PAGE_EXT0 = 2'h0;
  localparam logic [1:0] PAGE_DIAG = 2'h2;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] COUNT_ZERO = 8'h00;

  // ****************************************
  // Coding-sublayer config fields
  // ****************************************
  localparam int FLD_FREE_CLK = 11;
  localparam int FLD_QUIET_TX = 10;
  localparam int FLD_SD_FORCE = 9;
  localparam int FLD_SIGNAL_DETECT_OPTION = 8;
  localparam int FLD_DESC_LONG = 7;
  localparam int FLD_FIBER = 6;
  localparam int FLD_FORCE_GOOD = 5;
  localparam logic RST_SIGNAL_DETECT_OPTION = 1'b1;

  // ****************************************
  // Management frame
  // ****************************************
  localparam logic [4:0] PHY_ADDR_PORT0 = 5'h01;
  localparam logic [4:0] PHY_ADDR_PORT1 = 5'h02;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] OP_BITS_LAST = 5'h01;
  localparam logic [4:0] ADDR_BITS_LAST = 5'h09;
  localparam logic [4:0] DATA_BITS_LAST = 5'h0F;
  localparam logic [4:0] DATA_BITS_DONE = 5'h10;
  localparam logic [4:0] TA_BITS_LAST = 5'h01;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int DESC_TIMEOUT_SHORT_NS = 722000;
  localparam int DESC_TIMEOUT_LONG_NS = 2000000;
  localparam int DESC_TIMEOUT_SHORT_CYC = DESC_TIMEOUT_SHORT_NS / CLK_PERIOD_NS;
  localparam int DESC_TIMEOUT_LONG_CYC = DESC_TIMEOUT_LONG_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 17;

endpackage

// ==== core/phy_port_regs.sv ====
// One port's page selector, event counters and coding-sublayer config
`timescale 1ns/10ps
`default_nettype none
module phy_port_regs #(
  parameter logic [16:0] TIMEOUT_SHORT_CYC = 17'(phy_mgmt_pkg::DESC_TIMEOUT_SHORT_CYC),
  parameter logic [16:0] TIMEOUT_LONG_CYC = 17'(phy_mgmt_pkg::DESC_TIMEOUT_LONG_CYC)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  input wire logic fiber_strap,
  input wire logic false_carrier_evt,
  input wire logic carrier_valid,
  input wire logic symbol_invalid,
  input wire logic collision,
  input wire logic signal_level_ok,
  input wire logic descrambler_sync,
  output logic rx_clk_free_run,
  output logic quiet_transmit_enable,
  output logic signal_detect_force,
  output logic fiber_mode_enable,
  output logic descrambler_locked,
  output logic link_good
);

  typedef struct packed {
    logic [1:0] page;
    logic [7:0] fc_cnt;
    logic [7:0] re_cnt;
    logic carrier_d;
    logic err_seen;
    logic col_seen;
    logic free_clk;
    logic quiet;
    logic sd_force;
    logic signal_detect_option;
    logic desc_long;
    logic fiber;
    logic force_good;
    logic [1:0] strap_sync;
    logic lock;
    logic [16:0] lock_timer;
    logic link;
    logic good;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  logic sig_valid;
  logic [16:0] timeout_lim;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == phy_mgmt_pkg::COUNT_MAX) ? v : v + phy_mgmt_pkg::COUNT_ONE;
  endfunction

  function automatic logic in_page0(input logic [4:0] a, input logic [1:0] pg);
    in_page0 = (a < phy_mgmt_pkg::ADDR_PAGED_LO) || (a > phy_mgmt_pkg::ADDR_PAGED_HI) ||
               (pg == phy_mgmt_pkg::PAGE_EXT0);
  endfunction

  // ****************************************
  // Register read
  // ****************************************
  always_comb begin
    rdata = phy_mgmt_pkg::ZERO16;
    if (in_page0(reg_addr, st_r.page)) begin
      case (reg_addr)
        phy_mgmt_pkg::ADDR_PAGE_SEL: rdata = {14'h0000, st_r.page};
        phy_mgmt_pkg::ADDR_FALSE_CARRIER: rdata = {8'h00, st_r.fc_cnt};
        phy_mgmt_pkg::ADDR_RX_ERROR: rdata = {8'h00, st_r.re_cnt};
        phy_mgmt_pkg::ADDR_CODING_CFG: begin
          rdata[phy_mgmt_pkg::FLD_FREE_CLK] = st_r.free_clk;
          rdata[phy_mgmt_pkg::FLD_QUIET_TX] = st_r.quiet;
          rdata[phy_mgmt_pkg::FLD_SD_FORCE] = st_r.sd_force;
          rdata[phy_mgmt_pkg::FLD_SIGNAL_DETECT_OPTION] = st_r.signal_detect_option;
          rdata[phy_mgmt_pkg::FLD_DESC_LONG] = st_r.desc_long;
          rdata[phy_mgmt_pkg::FLD_FIBER] = st_r.fiber;
          rdata[phy_mgmt_pkg::FLD_FORCE_GOOD] = st_r.force_good;
        end
        default: rdata = phy_mgmt_pkg::ZERO16;
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    sig_valid = signal_level_ok | st_r.sd_force;
    timeout_lim = st_r.desc_long ? TIMEOUT_LONG_CYC : TIMEOUT_SHORT_CYC;
    st_nxt.strap_sync = {st_r.strap_sync[0], fiber_strap};
    // Read side effect first so a same-cycle event still counts
    if (rd_en && in_page0(reg_addr, st_r.page)) begin
      if (reg_addr == phy_mgmt_pkg::ADDR_FALSE_CARRIER) begin
        st_nxt.fc_cnt = phy_mgmt_pkg::COUNT_ZERO;
      end
      if (reg_addr == phy_mgmt_pkg::ADDR_RX_ERROR) begin
        st_nxt.re_cnt = phy_mgmt_pkg::COUNT_ZERO;
      end
    end
    if (false_carrier_evt) begin
      st_nxt.fc_cnt = sat_inc(st_nxt.fc_cnt);
    end
    // Per carrier tracking of errors and collisions
    st_nxt.carrier_d = carrier_valid;
    if (carrier_valid) begin
      st_nxt.err_seen = st_r.err_seen | symbol_invalid;
      st_nxt.col_seen = st_r.col_seen | collision;
    end else begin
      st_nxt.err_seen = 1'b0;
      st_nxt.col_seen = 1'b0;
    end
    if (st_r.carrier_d && !carrier_valid && st_r.err_seen && !st_r.col_seen) begin
      st_nxt.re_cnt = sat_inc(st_nxt.re_cnt);
    end
    if (wr_en && in_page0(reg_addr, st_r.page)) begin
      case (reg_addr)
        phy_mgmt_pkg::ADDR_PAGE_SEL: st_nxt.page = wdata[1:0];
        phy_mgmt_pkg::ADDR_CODING_CFG: begin
          st_nxt.free_clk = wdata[phy_mgmt_pkg::FLD_FREE_CLK];
          st_nxt.quiet = wdata[phy_mgmt_pkg::FLD_QUIET_TX];
          st_nxt.sd_force = wdata[phy_mgmt_pkg::FLD_SD_FORCE];
          st_nxt.signal_detect_option = wdata[phy_mgmt_pkg::FLD_SIGNAL_DETECT_OPTION];
          st_nxt.desc_long = wdata[phy_mgmt_pkg::FLD_DESC_LONG];
          st_nxt.fiber = wdata[phy_mgmt_pkg::FLD_FIBER];
          st_nxt.force_good = wdata[phy_mgmt_pkg::FLD_FORCE_GOOD];
        end
        default: st_nxt.page = st_r.page;
      endcase
    end
    // Descrambler lock with timeout
    if (descrambler_sync) begin
      st_nxt.lock = 1'b1;
      st_nxt.lock_timer = '0;
    end else if (st_r.lock) begin
      if (st_r.lock_timer >= timeout_lim) begin
        st_nxt.lock = 1'b0;
        st_nxt.lock_timer = '0;
      end else begin
        st_nxt.lock_timer = st_r.lock_timer + 17'h0_0001;
      end
    end
    // Link qualification
    if (!sig_valid) begin
      st_nxt.link = 1'b0;
    end else if (!st_r.link) begin
      st_nxt.link = st_r.lock;
    end else if (!st_r.signal_detect_option && !st_r.lock) begin
      st_nxt.link = 1'b0;
    end
    st_nxt.good = st_nxt.link | st_nxt.force_good;
    if (!rst_n) begin
      st_nxt = '0;
      st_nxt.strap_sync = {st_r.strap_sync[0], fiber_strap};
      st_nxt.signal_detect_option = phy_mgmt_pkg::RST_SIGNAL_DETECT_OPTION;
      st_nxt.fiber = st_r.strap_sync[1];
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign rx_clk_free_run = st_r.free_clk;
  assign quiet_transmit_enable = st_r.quiet;
  assign signal_detect_force = st_r.sd_force;
  assign fiber_mode_enable = st_r.fiber;
  assign descrambler_locked = st_r.lock;
  assign link_good = st_r.good;

endmodule // phy_port_regs
`default_nettype wire

// ==== core/phy_mgmt_top.sv ====
// Serial management slave serving the register slices of both ports
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_top #(
  parameter logic [16:0] TIMEOUT_SHORT_CYC = 17'(phy_mgmt_pkg::DESC_TIMEOUT_SHORT_CYC),
  parameter logic [16:0] TIMEOUT_LONG_CYC = 17'(phy_mgmt_pkg::DESC_TIMEOUT_LONG_CYC)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [1:0] fiber_strap,
  input wire logic [1:0] false_carrier_evt,
  input wire logic [1:0] carrier_valid,
  input wire logic [1:0] symbol_invalid,
  input wire logic [1:0] collision,
  input wire logic [1:0] signal_level_ok,
  input wire logic [1:0] descrambler_sync,
  output logic [1:0] rx_clk_free_run,
  output logic [1:0] quiet_transmit_enable,
  output logic [1:0] signal_detect_force,
  output logic [1:0] fiber_mode_enable,
  output logic [1:0] descrambler_locked,
  output logic [1:0] link_good
);

  typedef enum logic [2:0] {
    S_PRE = 3'b000,
    S_START = 3'b001,
    S_OP = 3'b010,
    S_ADDR = 3'b011,
    S_TA_RD = 3'b100,
    S_RDATA = 3'b101,
    S_TA_WR = 3'b110,
    S_WDATA = 3'b111
  } mgmt_fsm_t;

  typedef struct packed {
    mgmt_fsm_t fsm;
    logic [2:0] mdc_sync;
    logic [1:0] mdio_sync;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [1:0] op;
    logic [9:0] addr;
    logic [15:0] shift;
    logic rd_pulse;
    logic wr_pulse;
    logic sel;
    logic out;
    logic oe;
  } mgmt_state_t;

  mgmt_state_t st_r;
  mgmt_state_t st_nxt;
  logic [1:0] port_rd;
  logic [1:0] port_wr;
  logic [15:0] port_rdata [2];
  logic mdc_rise;
  logic mdc_fall;
  logic bit_in;
  logic [9:0] addr_next;
  logic hit0;
  logic hit1;

  // ****************************************
  // Port slices
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_port
      assign port_rd[gi] = st_r.rd_pulse && (st_r.sel == 1'(gi));
      assign port_wr[gi] = st_r.wr_pulse && (st_r.sel == 1'(gi));
      phy_port_regs #(
        .TIMEOUT_SHORT_CYC(TIMEOUT_SHORT_CYC),
        .TIMEOUT_LONG_CYC(TIMEOUT_LONG_CYC)
      ) u_port (
        .clk(clk),
        .rst_n(rst_n),
        .rd_en(port_rd[gi]),
        .wr_en(port_wr[gi]),
        .reg_addr(st_r.addr[4:0]),
        .wdata(st_r.shift),
        .rdata(port_rdata[gi]),
        .fiber_strap(fiber_strap[gi]),
        .false_carrier_evt(false_carrier_evt[gi]),
        .carrier_valid(carrier_valid[gi]),
        .symbol_invalid(symbol_invalid[gi]),
        .collision(collision[gi]),
        .signal_level_ok(signal_level_ok[gi]),
        .descrambler_sync(descrambler_sync[gi]),
        .rx_clk_free_run(rx_clk_free_run[gi]),
        .quiet_transmit_enable(quiet_transmit_enable[gi]),
        .signal_detect_force(signal_detect_force[gi]),
        .fiber_mode_enable(fiber_mode_enable[gi]),
        .descrambler_locked(descrambler_locked[gi]),
        .link_good(link_good[gi])
      );
    end
  endgenerate

  // ****************************************
  // Frame engine
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.mdc_sync = {st_r.mdc_sync[1:0], mdc};
    st_nxt.mdio_sync = {st_r.mdio_sync[0], mdio_in};
    st_nxt.rd_pulse = 1'b0;
    st_nxt.wr_pulse = 1'b0;
    mdc_rise = st_r.mdc_sync[1] && !st_r.mdc_sync[2];
    mdc_fall = !st_r.mdc_sync[1] && st_r.mdc_sync[2];
    bit_in = st_r.mdio_sync[1];
    addr_next = {st_r.addr[8:0], bit_in};
    hit0 = addr_next[9:5] == phy_mgmt_pkg::PHY_ADDR_PORT0;
    hit1 = addr_next[9:5] == phy_mgmt_pkg::PHY_ADDR_PORT1;
    // Capture read data before the clear-on-read takes effect
    if (st_r.rd_pulse) begin
      st_nxt.shift = port_rdata[st_r.sel];
    end
    case (st_r.fsm)
      S_PRE: begin
        if (mdc_rise) begin
          if (bit_in) begin
            if (st_r.ones != phy_mgmt_pkg::PREAMBLE_ONES) begin
              st_nxt.ones = st_r.ones + 6'h01;
            end
          end else begin
            st_nxt.ones = '0;
            if (st_r.ones == phy_mgmt_pkg::PREAMBLE_ONES) begin
              st_nxt.fsm = S_START;
            end
          end
        end
      end
      S_START: begin
        if (mdc_rise) begin
          st_nxt.cnt = '0;
          st_nxt.fsm = bit_in ? S_OP : S_PRE;
        end
      end
      S_OP: begin
        if (mdc_rise) begin
          st_nxt.op = {st_r.op[0], bit_in};
          st_nxt.cnt = st_r.cnt + 5'h01;
          if (st_r.cnt == phy_mgmt_pkg::OP_BITS_LAST) begin
            st_nxt.cnt = '0;
            st_nxt.fsm = S_ADDR;
          end
        end
      end
      S_ADDR: begin
        if (mdc_rise) begin
          st_nxt.addr = addr_next;
          st_nxt.cnt = st_r.cnt + 5'h01;
          if (st_r.cnt == phy_mgmt_pkg::ADDR_BITS_LAST) begin
            st_nxt.cnt = '0;
            st_nxt.sel = hit1;
            st_nxt.fsm = S_PRE;
            if (hit0 || hit1) begin
              if (st_r.op == phy_mgmt_pkg::OP_READ) begin
                st_nxt.rd_pulse = 1'b1;
                st_nxt.fsm = S_TA_RD;
              end else if (st_r.op == phy_mgmt_pkg::OP_WRITE) begin
                st_nxt.fsm = S_TA_WR;
              end
            end
          end
        end
      end
      S_TA_RD: begin
        if (mdc_fall) begin
          st_nxt.cnt = st_r.cnt + 5'h01;
          if (st_r.cnt == phy_mgmt_pkg::TA_BITS_LAST) begin
            st_nxt.oe = 1'b1;
            st_nxt.out = 1'b0;
            st_nxt.cnt = '0;
            st_nxt.fsm = S_RDATA;
          end
        end
      end
      S_RDATA: begin
        if (mdc_fall) begin
          if (st_r.cnt == phy_mgmt_pkg::DATA_BITS_DONE) begin
            st_nxt.oe = 1'b0;
            st_nxt.out = 1'b0;
            st_nxt.fsm = S_PRE;
          end else begin
            st_nxt.out = st_r.shift[15];
            st_nxt.shift = {st_r.shift[14:0], 1'b0};
            st_nxt.cnt = st_r.cnt + 5'h01;
          end
        end
      end
      S_TA_WR: begin
        if (mdc_rise) begin
          st_nxt.cnt = st_r.cnt + 5'h01;
          if (st_r.cnt == phy_mgmt_pkg::TA_BITS_LAST) begin
            st_nxt.cnt = '0;
            st_nxt.fsm = S_WDATA;
          end
        end
      end
      S_WDATA: begin
        if (mdc_rise) begin
          st_nxt.shift = {st_r.shift[14:0], bit_in};
          st_nxt.cnt = st_r.cnt + 5'h01;
          if (st_r.cnt == phy_mgmt_pkg::DATA_BITS_LAST) begin
            st_nxt.wr_pulse = 1'b1;
            st_nxt.cnt = '0;
            st_nxt.fsm = S_PRE;
          end
        end
      end
      default: st_nxt.fsm = S_PRE;
    endcase
    if (!rst_n) begin
      st_nxt = '0;
      st_nxt.mdc_sync = {st_r.mdc_sync[1:0], mdc};
      st_nxt.mdio_sync = {st_r.mdio_sync[0], mdio_in};
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign mdio_out = st_r.out;
  assign mdio_oe = st_r.oe;

endmodule // phy_mgmt_top
`default_nettype wire

// ==== test/phy_mgmt_monitor.sv ====
// Checker on the ports of the management slave top
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [1:0] fiber_strap,
  input wire logic [1:0] descrambler_sync,
  input wire logic [1:0] descrambler_locked,
  input wire logic [1:0] fiber_mode_enable,
  input wire logic [1:0] link_good
);
  // ****************************************
  // Count of mdc falls while driving
  // ****************************************
  logic [4:0] oe_falls_r;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk) begin
    if (!mdio_oe) begin
      oe_falls_r <= 5'h00;
    end else if ($fell(mdc)) begin
      oe_falls_r <= oe_falls_r + 5'h01;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_reset_idle_out: assert property ($rose(rst_n) |-> !mdio_oe && link_good == 2'b00)
    else $error("outputs not idle after reset");
  a_fiber_from_strap: assert property ($rose(rst_n) && fiber_strap == $past(fiber_strap, 5) |->
    fiber_mode_enable == fiber_strap) else $error("fiber bit differs from strap");
  a_lock_from_sync: assert property ($rose(descrambler_locked[0]) |-> $past(descrambler_sync[0]))
    else $error("lock set without sync");
  a_port1_lock_sync: assert property ($rose(descrambler_locked[1]) |-> $past(descrambler_sync[1]))
    else $error("port 1 lock set without sync");
  a_lock_holds: assert property (descrambler_sync[0] |=> descrambler_locked[0] [*8])
    else $error("lock lost too early");
  a_ta_drives_low: assert property ($rose(mdio_oe) |-> !mdio_out && !mdc)
    else $error("turnaround not low");
  a_out_moves_low: assert property (mdio_oe && $changed(mdio_out) |-> !mdc)
    else $error("data changed while mdc high");
  a_oe_bounded: assert property (oe_falls_r <= 5'h11)
    else $error("read answer too long");
  c_read_answer: cover property ($rose(mdio_oe));
  c_link_up: cover property ($rose(link_good[0]));
  c_lock_lost: cover property ($fell(descrambler_locked[0]));
endmodule // phy_mgmt_monitor
bind phy_mgmt_top phy_mgmt_monitor mon_u (.clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .fiber_strap(fiber_strap), .descrambler_sync(descrambler_sync),
  .descrambler_locked(descrambler_locked), .fiber_mode_enable(fiber_mode_enable), .link_good(link_good));
`default_nettype wire

// ==== test/mgmt_ctrl_model.sv ====
// Station management controller model driving mdc and mdio frames
`timescale 1ns/10ps
`default_nettype none
module mgmt_ctrl_model (
  input wire logic clk,
  input wire logic mdio_wire,
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_en
);
  // ****************************************
  // Bit and frame tasks
  // ****************************************
  localparam int HALF = 5;
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
    mdio_en = 1'b0;
  end
  task automatic bit_cycle(input logic en, input logic val, output logic smp);
    @(posedge clk);
    #1;
    mdio_en = en;
    mdio_drv = val;
    repeat (HALF - 1) @(posedge clk);
    #1;
    mdc = 1'b1;
    smp = mdio_wire;
    repeat (HALF) @(posedge clk);
    #1;
    mdc = 1'b0;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic wr;
    hdr = {2'b01, op, phy, ra};
    wr = (op == phy_mgmt_pkg::OP_WRITE);
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    bit_cycle(wr, 1'b1, s);
    bit_cycle(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(wr, wd[i], s);
      rd[i] = s;
    end
    bit_cycle(1'b0, 1'b1, s);
  endtask
endmodule // mgmt_ctrl_model
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the two-port management register slice
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [4:0] P0 = phy_mgmt_pkg::PHY_ADDR_PORT0;
  localparam logic [4:0] P1 = phy_mgmt_pkg::PHY_ADDR_PORT1;
  localparam logic [4:0] PG = phy_mgmt_pkg::ADDR_PAGE_SEL;
  localparam logic [4:0] FC = phy_mgmt_pkg::ADDR_FALSE_CARRIER;
  localparam logic [4:0] RE = phy_mgmt_pkg::ADDR_RX_ERROR;
  localparam logic [4:0] CF = phy_mgmt_pkg::ADDR_CODING_CFG;
  logic clk, rst_n;
  logic [1:0] fiber_strap, false_carrier_evt, carrier_valid, symbol_invalid, collision;
  logic [1:0] signal_level_ok, descrambler_sync;
  wire mdc, m_en, m_drv, mdio_out, mdio_oe, mdio_wire;
  wire [1:0] rx_clk_free_run, quiet_transmit_enable, signal_detect_force, fiber_mode_enable;
  wire [1:0] descrambler_locked, link_good;
  int n_errors = 0;
  int checks_done = 0;
  // Pulled-up shared data line
  assign mdio_wire = mdio_oe ? mdio_out : (m_en ? m_drv : 1'b1);
  phy_mgmt_top #(.TIMEOUT_SHORT_CYC(17'h0_0014), .TIMEOUT_LONG_CYC(17'h0_0032)) dut_u (
    .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .fiber_strap(fiber_strap), .false_carrier_evt(false_carrier_evt), .carrier_valid(carrier_valid),
    .symbol_invalid(symbol_invalid), .collision(collision), .signal_level_ok(signal_level_ok),
    .descrambler_sync(descrambler_sync), .rx_clk_free_run(rx_clk_free_run),
    .quiet_transmit_enable(quiet_transmit_enable), .signal_detect_force(signal_detect_force),
    .fiber_mode_enable(fiber_mode_enable), .descrambler_locked(descrambler_locked), .link_good(link_good));
  mgmt_ctrl_model mgmt_u (.clk(clk), .mdio_wire(mdio_wire), .mdc(mdc), .mdio_drv(m_drv), .mdio_en(m_en));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mgmt_u.frame(phy_mgmt_pkg::OP_WRITE, phy, ra, d, x);
  endtask
  task automatic rd_chk(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] x;
    mgmt_u.frame(phy_mgmt_pkg::OP_READ, phy, ra, 16'h0000, x);
    chk(x, exp);
  endtask
  task automatic fc_pulses(input int n);
    repeat (n) begin
      false_carrier_evt = 2'b01;
      step;
      false_carrier_evt = 2'b00;
      step;
    end
  endtask
  task automatic carrier(input logic bad, input logic col);
    carrier_valid = 2'b01;
    collision = {1'b0, col};
    repeat (2) begin
      step;
      symbol_invalid = {1'b0, bad};
      step;
      symbol_invalid = 2'b00;
    end
    step;
    carrier_valid = 2'b00;
    collision = 2'b00;
    step;
  endtask
  task automatic sync_wait(input int n);
    descrambler_sync = 2'b01;
    step;
    descrambler_sync = 2'b00;
    repeat (n) step;
  endtask
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    print_verdict;
  end
  initial begin
    rst_n = 1'b0;
    fiber_strap = 2'b01;
    {false_carrier_evt, carrier_valid, symbol_invalid, collision, descrambler_sync} = 10'h000;
    signal_level_ok = 2'b11;
    repeat (12) step;
    rst_n = 1'b1;
    step;
    chk({14'h0000, fiber_mode_enable}, 16'h0001);
    rd_chk(P0, CF, 16'h0140);
    rd_chk(P1, CF, 16'h0100);
    wr(P0, PG, 16'hFFFF);
    rd_chk(P0, PG, 16'h0003);
    rd_chk(P0, CF, 16'h0000);
    wr(P0, PG, 16'h0002);
    wr(P0, CF, 16'h0F00);
    rd_chk(P0, CF, 16'h0000);
    wr(P0, PG, 16'h0000);
    rd_chk(P0, CF, 16'h0140);
    wr(P0, CF, 16'hFFFF);
    rd_chk(P0, CF, 16'h0FE0);
    chk({8'h00, rx_clk_free_run, quiet_transmit_enable, signal_detect_force, fiber_mode_enable}, 16'h0055);
    chk({14'h0000, link_good}, 16'h0001);
    wr(P0, CF, 16'h0000);
    chk({8'h00, rx_clk_free_run, quiet_transmit_enable, signal_detect_force, fiber_mode_enable}, 16'h0000);
    sync_wait(3);
    chk({12'h000, descrambler_locked, link_good}, 16'h0005);
    sync_wait(33);
    chk({12'h000, descrambler_locked, link_good}, 16'h0000);
    wr(P0, CF, 16'h0100);
    sync_wait(33);
    chk({12'h000, descrambler_locked, link_good}, 16'h0001);
    signal_level_ok = 2'b10;
    repeat (3) step;
    chk({14'h0000, link_good}, 16'h0000);
    wr(P0, CF, 16'h0300);
    sync_wait(3);
    chk({14'h0000, link_good}, 16'h0001);
    signal_level_ok = 2'b11;
    wr(P0, CF, 16'h0080);
    sync_wait(33);
    chk({14'h0000, descrambler_locked}, 16'h0001);
    repeat (25) step;
    chk({14'h0000, descrambler_locked}, 16'h0000);
    fc_pulses(3);
    rd_chk(P0, FC, 16'h0003);
    wr(P0, FC, 16'h00AA);
    fc_pulses(1);
    rd_chk(P0, FC, 16'h0001);
    fc_pulses(300);
    rd_chk(P0, FC, 16'h00FF);
    rd_chk(P0, FC, 16'h0000);
    rd_chk(P1, FC, 16'h0000);
    carrier(1'b1, 1'b0);
    carrier(1'b1, 1'b1);
    carrier(1'b0, 1'b0);
    rd_chk(P0, RE, 16'h0001);
    repeat (260) carrier(1'b1, 1'b0);
    rd_chk(P0, RE, 16'h00FF);
    rd_chk(P0, RE, 16'h0000);
    fiber_strap = 2'b10;
    repeat (10) step;
    rst_n = 1'b0;
    repeat (12) step;
    rst_n = 1'b1;
    step;
    chk({14'h0000, fiber_mode_enable}, 16'h0002);
    rd_chk(P1, CF, 16'h0140);
    descrambler_sync = 2'b10;
    step;
    descrambler_sync = 2'b00;
    repeat (3) step;
    chk({12'h000, descrambler_locked, link_good}, 16'h000A);
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
